// ==== design/wfd_wake_frame_detector.sv ====
// wake-up frame filters, link change detection and remote wake output
`timescale 1ns/100ps
`include "wfd_params.svh"

// Functional notes
// [RULE1] four independent filters, each spanning 32 contiguous frame bytes
// [RULE2] byte offset plus j is checked when mask bit j is set
// [RULE3] CRC-16 over selected bytes only, compared with stored remainder
// [RULE4] generator polynomial x16 + x15 + x2 + 1
// [RULE5] match needs equal CRC and filter enable; disabled never wakes
// [RULE6] chaining off: any single matching filter wakes
// [RULE7] chaining select combines filters in the four fixed ways
// [RULE8] chain enable is bit 4, chain select bits 26 and 25
// [RULE9] driver programs contiguous offsets for frames of 32 to 128 bytes
// [RULE10] frame event needs sleep, address match, good CRC32, pm enable
// [RULE11] link event needs sleep, pm enable and cable re-connected
// [RULE12] station identity loads from serial memory at main power-up
// [RULE13] main power off enters remote power-on mode, wake on frames
// [RULE14] pci reset clears wake output; mode can be re-entered later
// [RULE15] four CRC references held two per register, 16 bits each
// [RULE16] any wake event sets pme and irq status, drives wake outputs
// [RULE17] driver keeps each pattern offset above 12
// [RULE18] CRC starts at zero, bytes in frame order, lsb first
module wfd_wake_frame_detector #(
    parameter int NUM_FILT = 4,
    parameter int WIN      = `WFD_WIN_BYTES
) (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic                     clk_en,
    input  wire logic [`WFD_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    input  wire wfd_pkg::wfd_rx_beat_t    rx_beat,
    input  wire logic                     fully_on,
    input  wire logic                     main_power_ok,
    input  wire logic                     link_up,
    input  wire logic                     remote_wake_frame,
    input  wire logic                     id_load_valid,
    input  wire logic [47:0]              id_load_data,
    output logic                          id_load_req,
    output logic                          irq,
    output logic                          pme_out_n,
    output logic                          ext_start_out_n,
    output logic                          remote_wake_out,
    output logic                          remote_power_on_mode
);

    // =========================================================
    // register storage
    logic [31:0]             mask_ff [NUM_FILT];
    wfd_pkg::wfd_ofsen_t     ofsen_ff [NUM_FILT];
    logic [15:0]             ref_ff [NUM_FILT];
    logic                    filter_chain_enable_ff;
    logic [1:0]              filter_chain_select_ff;
    logic                    power_mgmt_enable_ff;
    logic                    pme_stat_ff;
    logic [2:0]              wake_irq_status_ff;
    logic [2:0]              irq_mask_ff;
    logic [47:0]             station_ff;
    logic                    id_loaded_ff;
    logic                    remote_wake_ff;
    logic                    rpo_ff;
    logic                    link_up_ff;
    logic [10:0]             pos_ff;
    logic [15:0]             crc_ff [NUM_FILT];
    logic                    frame_ev;
    logic                    link_ev;
    logic                    any_ev;
    logic                    wr_st;
    logic [2:0]              ev_bits;
    logic [NUM_FILT-1:0]     hit;
    logic                    chain_hit;
    logic [31:0]             rd_nxt;

    // crc step, lsb first, shifting polynomial form
    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                               input logic [7:0]  d);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[15] ^ d[i];
            r  = {r[14:0], 1'b0} ^ (fb ? `WFD_CRC_POLY : 16'h0000); // [RULE4]
        end
        return r;
    endfunction

    function automatic logic wr_at(input logic [`WFD_ADDR_W-1:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    // =========================================================
    // filter registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int k = 0; k < NUM_FILT; k++) begin
                mask_ff[k]  <= `WFD_RST_WORD;
                ofsen_ff[k] <= '0;
                ref_ff[k]   <= 16'h0000;
            end
        end else if (clk_en) begin
            for (int k = 0; k < NUM_FILT; k++) begin
                if (wr_at(8'(k * 4)))
                    mask_ff[k] <= reg_wdata;
                if (wr_at(`WFD_OFS_OFSEN))
                    ofsen_ff[k] <= reg_wdata[k*8 +: 8];
            end
            if (wr_at(`WFD_OFS_CRC01)) begin
                ref_ff[0] <= reg_wdata[15:0];  // [RULE15]
                ref_ff[1] <= reg_wdata[31:16]; // [RULE15]
            end
            if (wr_at(`WFD_OFS_CRC23)) begin
                ref_ff[2] <= reg_wdata[15:0];  // [RULE15]
                ref_ff[3] <= reg_wdata[31:16]; // [RULE15]
            end
        end
    end

    // =========================================================
    // control registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            filter_chain_enable_ff <= 1'b0;
            filter_chain_select_ff <= 2'h0;
            power_mgmt_enable_ff   <= 1'b0;
            irq_mask_ff            <= 3'h0;
        end else if (clk_en) begin
            if (wr_at(`WFD_OFS_CHAIN_EN))
                filter_chain_enable_ff <=
                    reg_wdata[`WFD_CHAIN_EN_BIT]; // [RULE8]
            if (wr_at(`WFD_OFS_CHAIN_SEL))
                filter_chain_select_ff <=
                    reg_wdata[`WFD_CHAIN_SEL_HI:`WFD_CHAIN_SEL_LO]; // [RULE8]
            if (wr_at(`WFD_OFS_PMCS))
                power_mgmt_enable_ff <= reg_wdata[`WFD_PM_EN_BIT];
            if (wr_at(`WFD_OFS_IRQ_MASK))
                irq_mask_ff <= reg_wdata[2:0];
        end
    end

    // =========================================================
    // station identity load at power-up
    assign id_load_req = !id_loaded_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            id_loaded_ff <= 1'b0;
            station_ff   <= 48'h0;
        end else if (clk_en && !id_loaded_ff && id_load_valid) begin
            id_loaded_ff <= 1'b1;         // [RULE12]
            station_ff   <= id_load_data; // [RULE12]
        end
    end

    // =========================================================
    // per-filter CRC over the selected window
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            pos_ff <= 11'h000;
        else if (clk_en && rx_beat.valid)
            pos_ff <= rx_beat.sof ? 11'h001 : pos_ff + 11'h001;
    end

    logic [10:0] cur_pos;
    assign cur_pos = rx_beat.sof ? 11'h000 : pos_ff;

    generate
        for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
            logic [10:0] rel;
            logic        sel;
            logic [15:0] base;
            assign rel  = cur_pos - {4'h0, ofsen_ff[g].offset}; // [RULE2]
            assign sel  = (cur_pos >= {4'h0, ofsen_ff[g].offset}) &&
                          (rel < 11'(WIN)) &&
                          mask_ff[g][rel[4:0]];                // [RULE1]
            assign base = rx_beat.sof ? `WFD_CRC_INIT : crc_ff[g]; // [RULE18]

            always_ff @(posedge clk_sys) begin
                if (sys_rst)
                    crc_ff[g] <= `WFD_CRC_INIT;
                else if (clk_en && rx_beat.valid)
                    crc_ff[g] <= sel ? crc16_byte(base, rx_beat.data)
                                     : base; // [RULE3]
            end

            logic [15:0] fin;
            assign fin    = (rx_beat.valid && sel) ?
                            crc16_byte(base, rx_beat.data) : base;
            assign hit[g] = ofsen_ff[g].en && (fin == ref_ff[g]); // [RULE5]
        end
    endgenerate

    // =========================================================
    // chaining and wake events
    always_comb begin
        if (!filter_chain_enable_ff) begin
            chain_hit = |hit; // [RULE6]
        end else begin
            case (wfd_pkg::wfd_chain_t'(filter_chain_select_ff)) // [RULE7]
                wfd_pkg::WFD_CH_PAIRS:
                    chain_hit = (hit[0] & hit[1]) | (hit[2] & hit[3]);
                wfd_pkg::WFD_CH_PAIR_2_3:
                    chain_hit = (hit[0] & hit[1]) | hit[2] | hit[3];
                wfd_pkg::WFD_CH_TRIPLE_3:
                    chain_hit = (hit[0] & hit[1] & hit[2]) | hit[3];
                wfd_pkg::WFD_CH_ALL:
                    chain_hit = &hit;
                default:
                    chain_hit = 1'b0;
            endcase
        end
    end

    assign frame_ev = rx_beat.valid && rx_beat.eof && chain_hit &&
                      !fully_on && rx_beat.da_match &&
                      !rx_beat.crc32_err && power_mgmt_enable_ff; // [RULE10]
    assign link_ev  = link_up && !link_up_ff && !fully_on &&
                      power_mgmt_enable_ff; // [RULE11]
    assign any_ev   = frame_ev || link_ev ||
                      (remote_wake_frame && !fully_on && power_mgmt_enable_ff);
    assign ev_bits  = {any_ev, link_ev, frame_ev};
    assign wr_st    = wr_at(`WFD_OFS_STATUS);

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            link_up_ff <= 1'b0;
        else if (clk_en)
            link_up_ff <= link_up;
    end

    // =========================================================
    // status, pme and interrupt; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wake_irq_status_ff <= 3'h0;
            pme_stat_ff        <= 1'b0;
        end else if (clk_en) begin
            wake_irq_status_ff <= (wake_irq_status_ff &
                                   ~(wr_st ? reg_wdata[2:0] : 3'h0)) |
                                  ev_bits; // [RULE16]
            if (any_ev)
                pme_stat_ff <= 1'b1; // [RULE16]
            else if (wr_at(`WFD_OFS_PMCS) && reg_wdata[`WFD_PME_STAT_BIT])
                pme_stat_ff <= 1'b0;
        end
    end

    assign irq             = |(wake_irq_status_ff & irq_mask_ff); // [RULE16]
    assign pme_out_n       = !pme_stat_ff;    // [RULE16]
    assign ext_start_out_n = !remote_wake_ff;
    assign remote_wake_out = remote_wake_ff;
    assign remote_power_on_mode = rpo_ff;

    // =========================================================
    // remote power-on mode and wake output; sys_rst is the pci reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rpo_ff         <= 1'b0; // [RULE14]
            remote_wake_ff <= 1'b0; // [RULE14]
        end else if (clk_en) begin
            if (!main_power_ok && id_loaded_ff)
                rpo_ff <= 1'b1; // [RULE13]
            if (any_ev)
                remote_wake_ff <= 1'b1; // [RULE13]
        end
    end

    // =========================================================
    // read port
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (reg_addr)
            `WFD_OFS_MASK0:    rd_nxt = mask_ff[0];
            `WFD_OFS_MASK1:    rd_nxt = mask_ff[1];
            `WFD_OFS_MASK2:    rd_nxt = mask_ff[2];
            `WFD_OFS_MASK3:    rd_nxt = mask_ff[3];
            `WFD_OFS_OFSEN:    rd_nxt = {ofsen_ff[3], ofsen_ff[2],
                                         ofsen_ff[1], ofsen_ff[0]};
            `WFD_OFS_CRC01:    rd_nxt = {ref_ff[1], ref_ff[0]};
            `WFD_OFS_CRC23:    rd_nxt = {ref_ff[3], ref_ff[2]};
            `WFD_OFS_CHAIN_EN:
                rd_nxt[`WFD_CHAIN_EN_BIT] = filter_chain_enable_ff;
            `WFD_OFS_CHAIN_SEL:
                rd_nxt[`WFD_CHAIN_SEL_HI:`WFD_CHAIN_SEL_LO] =
                    filter_chain_select_ff;
            `WFD_OFS_PMCS: begin
                rd_nxt[`WFD_PM_EN_BIT]   = power_mgmt_enable_ff;
                rd_nxt[`WFD_PME_STAT_BIT] = pme_stat_ff;
            end
            `WFD_OFS_STATUS:   rd_nxt[2:0] = wake_irq_status_ff;
            `WFD_OFS_IRQ_MASK: rd_nxt[2:0] = irq_mask_ff;
            `WFD_OFS_STATION:  rd_nxt = {rpo_ff, id_loaded_ff, 14'h0000,
                                         station_ff[47:32]};
            default:           rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en)
            reg_rdata <= reg_rd ? rd_nxt : 32'h0000_0000;
    end

    // =========================================================
    // assertions
    a_disabled_no_hit: assert property ( // [RULE5]
        @(posedge clk_sys) disable iff (sys_rst)
        !ofsen_ff[0].en |-> !hit[0])
        else $error("disabled filter hit");

    a_pairs_chain: assert property ( // [RULE7]
        @(posedge clk_sys) disable iff (sys_rst)
        (filter_chain_enable_ff && filter_chain_select_ff == 2'h0 &&
         hit == 4'b0101) |-> !chain_hit)
        else $error("pair chain wrong");

    a_all_chain: assert property ( // [RULE7]
        @(posedge clk_sys) disable iff (sys_rst)
        (filter_chain_enable_ff && filter_chain_select_ff == 2'h3 &&
         hit != 4'hf) |-> !chain_hit)
        else $error("all chain wrong");

    a_indep_any: assert property ( // [RULE6]
        @(posedge clk_sys) disable iff (sys_rst)
        (!filter_chain_enable_ff && hit != 4'h0) |-> chain_hit)
        else $error("independent miss");

    a_frame_gates: assert property ( // [RULE10]
        @(posedge clk_sys) disable iff (sys_rst)
        frame_ev |-> (!fully_on && power_mgmt_enable_ff &&
                      !rx_beat.crc32_err && rx_beat.da_match))
        else $error("frame event ungated");

    a_link_gates: assert property ( // [RULE11]
        @(posedge clk_sys) disable iff (sys_rst)
        link_ev |-> (!fully_on && power_mgmt_enable_ff && !$past(link_up)))
        else $error("link event ungated");

    a_event_status: assert property ( // [RULE16]
        @(posedge clk_sys) disable iff (sys_rst)
        (clk_en && any_ev) |=> (wake_irq_status_ff[2] && !pme_out_n &&
                                remote_wake_out))
        else $error("event not recorded");

    a_status_sticky: assert property ( // [RULE16]
        @(posedge clk_sys) disable iff (sys_rst)
        (clk_en && wake_irq_status_ff[0] && !wr_st)
        |=> wake_irq_status_ff[0])
        else $error("frame status lost");

    a_wake_hold: assert property ( // [RULE14]
        @(posedge clk_sys) disable iff (sys_rst)
        remote_wake_out |=> remote_wake_out)
        else $error("wake dropped without reset");

    a_rpo_enter: assert property ( // [RULE13]
        @(posedge clk_sys) disable iff (sys_rst)
        (clk_en && !main_power_ok && id_loaded_ff)
        |=> remote_power_on_mode)
        else $error("power-on mode not entered");

    a_rpo_hold: assert property ( // [RULE14]
        @(posedge clk_sys) disable iff (sys_rst)
        remote_power_on_mode |=> remote_power_on_mode)
        else $error("power-on mode dropped without reset");

    a_crc_start: assert property ( // [RULE18]
        @(posedge clk_sys) disable iff (sys_rst)
        (clk_en && rx_beat.valid && rx_beat.sof && !g_filt[0].sel) |=>
        crc_ff[0] == 16'h0000)
        else $error("crc not seeded");

endmodule

// ==== design/wfd_params.svh ====
// offsets, field positions, reset values and CRC constants of the wake block
`ifndef WFD_PARAMS_SVH
`define WFD_PARAMS_SVH

// =============================================================
// register offsets
`define WFD_ADDR_W         8
`define WFD_OFS_MASK0      8'h00
`define WFD_OFS_MASK1      8'h04
`define WFD_OFS_MASK2      8'h08
`define WFD_OFS_MASK3      8'h0c
`define WFD_OFS_OFSEN      8'h10
`define WFD_OFS_CRC01      8'h14
`define WFD_OFS_CRC23      8'h18
`define WFD_OFS_CHAIN_EN   8'h1c
`define WFD_OFS_CHAIN_SEL  8'h20
`define WFD_OFS_PMCS       8'h24
`define WFD_OFS_STATUS     8'h28
`define WFD_OFS_IRQ_MASK   8'h2c
`define WFD_OFS_STATION    8'h30

// =============================================================
// field positions
`define WFD_CHAIN_EN_BIT   4
`define WFD_CHAIN_SEL_HI   26
`define WFD_CHAIN_SEL_LO   25
`define WFD_PM_EN_BIT      8
`define WFD_PME_STAT_BIT   15
`define WFD_ST_FRAME_BIT   0
`define WFD_ST_LINK_BIT    1
`define WFD_ST_WAKE_BIT    2

// =============================================================
// reset values and CRC constants
`define WFD_RST_WORD       32'h0000_0000
`define WFD_CRC_POLY       16'h8005
`define WFD_CRC_INIT       16'h0000
`define WFD_WIN_BYTES      32

`endif

// ==== design/wfd_pkg.sv ====
// types shared by the wake frame detector
package wfd_pkg;

    typedef struct packed {
        logic       sof;
        logic       valid;
        logic [7:0] data;
        logic       eof;
        logic       da_match;
        logic       crc32_err;
    } wfd_rx_beat_t;

    typedef struct packed {
        logic       en;
        logic [6:0] offset;
    } wfd_ofsen_t;

    typedef enum logic [1:0] {
        WFD_CH_PAIRS,
        WFD_CH_PAIR_2_3,
        WFD_CH_TRIPLE_3,
        WFD_CH_ALL
    } wfd_chain_t;

endpackage

// ==== tb/wfd_rx_partner.sv ====
// receive path and serial identity memory model facing the wake block
`timescale 1ns/100ps
module wfd_rx_partner #(
    parameter logic [47:0] STATION = 48'h0a1b_2c3d_4e5f // arbitrary value
) (
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    input  wire logic            id_load_req,
    output wfd_pkg::wfd_rx_beat_t rx_beat,
    output logic                 id_load_valid,
    output logic [47:0]          id_load_data
);
    logic [2:0] cnt_ff;

    // =============================================================
    // serial identity memory: answers a load request after a delay
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !id_load_req) begin
            cnt_ff <= 3'h0;
        end else if (cnt_ff != 3'h7) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end
    assign id_load_valid = (cnt_ff == 3'h4);
    assign id_load_data  = id_load_valid ? STATION : ~STATION;

    // =============================================================
    // frame source, one byte per beat, optional idle gaps
    function automatic logic [7:0] fbyte(int i);
        return 8'(i * 29 + 90);
    endfunction

    task automatic idle(int i);
        rx_beat <= '{sof: 1'h0, valid: 1'h0, data: ~fbyte(i), eof: 1'h0,
                     da_match: 1'h0, crc32_err: 1'h1};
    endtask

    task automatic send(int len, logic da, logic err, int gap);
        for (int i = 0; i < len; i++) begin
            @(posedge clk_sys);
            rx_beat <= '{sof: i == 0, valid: 1'h1, data: fbyte(i),
                         eof: i == len - 1, da_match: da, crc32_err: err};
            if (gap > 0 && i % gap == 0) begin
                @(posedge clk_sys);
                idle(i);
            end
        end
        @(posedge clk_sys);
        idle(len);
    endtask

    initial idle(0);
endmodule

// ==== tb/wfd_wake_frame_detector_bench.sv ====
// self-checking bench of the wake frame detector
`timescale 1ns/100ps
`include "wfd_params.svh"
module wfd_wake_frame_detector_bench;
    // =============================================================
    // signals and instances
    logic                  clk_sys = 1'h0;
    logic                  sys_rst = 1'h1;
    logic                  clk_en = 1'h1;
    logic [7:0]            reg_addr = 8'h00;
    logic [31:0]           reg_wdata = 32'h0;
    logic                  reg_wr = 1'h0;
    logic                  reg_rd = 1'h0;
    logic [31:0]           reg_rdata;
    wfd_pkg::wfd_rx_beat_t rx_beat;
    logic                  fully_on = 1'h0;
    logic                  main_power_ok = 1'h1;
    logic                  link_up = 1'h0;
    logic                  remote_wake_frame = 1'h0;
    logic                  id_load_valid;
    logic [47:0]           id_load_data;
    logic                  id_load_req;
    logic                  irq;
    logic                  pme_out_n;
    logic                  ext_start_out_n;
    logic                  remote_wake_out;
    logic                  remote_power_on_mode;
    int                    n_fail = 0;
    int                    tests_run = 0;

    always #12.5 clk_sys = ~clk_sys;

    wfd_wake_frame_detector uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_beat(rx_beat),
        .fully_on(fully_on), .main_power_ok(main_power_ok),
        .link_up(link_up), .remote_wake_frame(remote_wake_frame),
        .id_load_valid(id_load_valid), .id_load_data(id_load_data),
        .id_load_req(id_load_req), .irq(irq), .pme_out_n(pme_out_n),
        .ext_start_out_n(ext_start_out_n),
        .remote_wake_out(remote_wake_out),
        .remote_power_on_mode(remote_power_on_mode));

    wfd_rx_partner src (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .id_load_req(id_load_req),
        .rx_beat(rx_beat), .id_load_valid(id_load_valid),
        .id_load_data(id_load_data));

    // =============================================================
    // compare, bus and helper tasks
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk32(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(logic got, logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        #1;
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask

    task automatic rdchk(logic [7:0] a, logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk32(d, exp);
    endtask

    task automatic pulse_rst();
        @(posedge clk_sys);
        sys_rst <= 1'h1;
        @(posedge clk_sys);
        sys_rst <= 1'h0;
        #1;
    endtask

    task automatic wait_id();
        int i;
        i = 0;
        while (id_load_req !== 1'h0 && i < 100) begin
            @(posedge clk_sys);
            #1 i++;
        end
        chk1(id_load_req, 1'h0);
        if (id_load_req !== 1'h0) stop_test();
    endtask

    function automatic logic [31:0] msk(int k);
        return 32'h8000_0001 | (32'h0123_4567 << k);
    endfunction

    function automatic logic [15:0] crc_of(int ofs, logic [31:0] m);
        logic [15:0] c;
        logic [7:0]  b;
        c = 16'h0000;
        for (int j = 0; j < 32; j++) begin
            b = src.fbyte(ofs + j);
            if (m[j])
                for (int t = 0; t < 8; t++)
                    c = {c[14:0], 1'h0} ^
                        (c[15] ^ b[t] ? 16'h8005 : 16'h0);
        end
        return c;
    endfunction

    function automatic logic exp_w(int c, logic [3:0] m);
        case (c)
            0: return (m[0] & m[1]) | (m[2] & m[3]);
            1: return (m[0] & m[1]) | m[2] | m[3];
            2: return (m[0] & m[1] & m[2]) | m[3];
            3: return &m;
            default: return |m;
        endcase
    endfunction

    task automatic setup(logic [3:0] en, logic [3:0] good);
        logic [31:0] oe;
        logic [15:0] r [4];
        for (int k = 0; k < 4; k++) begin
            oe[8*k+:8] = {en[k], 7'(13 + 32 * k)};
            r[k] = crc_of(13 + 32 * k, msk(k)) ^ {15'h0, !good[k]};
            wr(`WFD_OFS_MASK0 + 8'(4 * k), msk(k));
        end
        wr(`WFD_OFS_OFSEN, oe);
        wr(`WFD_OFS_CRC01, {r[1], r[0]});
        wr(`WFD_OFS_CRC23, {r[3], r[2]});
    endtask

    // cond: 0 pm enable, 1 address match, 2 crc32 error, 3 fully on
    task automatic frame_case(int c, logic [3:0] en, logic [3:0] good,
                              logic [3:0] cond, int gap, logic exp);
        logic [31:0] d;
        setup(en, good);
        wr(`WFD_OFS_CHAIN_EN, {27'h0, c < 4, 4'h0});
        wr(`WFD_OFS_CHAIN_SEL, {5'h0, 2'(c), 25'h0});
        wr(`WFD_OFS_PMCS, {23'h0, cond[0], 8'h0});
        fully_on <= cond[3];
        src.send(141, cond[1], cond[2], gap);
        rd(`WFD_OFS_STATUS, d);
        chk32(d & 32'h5, {29'h0, exp, 1'h0, exp});
        rd(`WFD_OFS_PMCS, d);
        chk1(d[15], exp);
        wr(`WFD_OFS_STATUS, 32'h7);
        wr(`WFD_OFS_PMCS, 32'h8000);
        fully_on <= 1'h0;
    endtask

    // =============================================================
    // scenarios
    task automatic t_reg();
        logic [31:0] d;
        #1 chk1(pme_out_n, 1'h1);
        chk1(remote_wake_out, 1'h0);
        chk1(irq, 1'h0);
        for (int a = 0; a < 12; a++) rdchk(8'(4 * a), 32'h0);
        wr(`WFD_OFS_MASK0, 32'ha5a5_5a5a);
        rdchk(`WFD_OFS_MASK0, 32'ha5a5_5a5a);
        wr(8'h40, 32'hffff_ffff);
        rdchk(8'h40, 32'h0);
        clk_en <= 1'h0;
        wr(`WFD_OFS_CRC01, 32'h1234_5678);
        clk_en <= 1'h1;
        rdchk(`WFD_OFS_CRC01, 32'h0);
        wait_id();
        rd(`WFD_OFS_STATION, d);
        chk32(d & 32'hc000_ffff,
              {2'h1, 14'h0, src.STATION[47:32]});
    endtask

    task automatic t_irq();
        wr(`WFD_OFS_IRQ_MASK, 32'h1);
        setup(4'h1, 4'h1);
        wr(`WFD_OFS_PMCS, 32'h100);
        src.send(141, 1'h1, 1'h0, 0);
        @(posedge clk_sys);
        #1 chk1(irq, 1'h1);
        chk1(pme_out_n, 1'h0);
        chk1(ext_start_out_n, 1'h0);
        chk1(remote_wake_out, 1'h1);
        wr(`WFD_OFS_IRQ_MASK, 32'h2);
        chk1(irq, 1'h0);
        wr(`WFD_OFS_IRQ_MASK, 32'h1);
        wr(`WFD_OFS_STATUS, 32'h7);
        chk1(irq, 1'h0);
        wr(`WFD_OFS_PMCS, 32'h8000);
        chk1(pme_out_n, 1'h1);
    endtask

    task automatic t_gate();
        frame_case(4, 4'hf, 4'h0, 4'h3, 0, 1'h0);
        frame_case(4, 4'h1, 4'h1, 4'h3, 0, 1'h1);
        frame_case(4, 4'h8, 4'h8, 4'h3, 1, 1'h1);
        frame_case(4, 4'hf, 4'hf, 4'hb, 0, 1'h0);
        frame_case(4, 4'hf, 4'hf, 4'h1, 0, 1'h0);
        frame_case(4, 4'hf, 4'hf, 4'h7, 0, 1'h0);
        frame_case(4, 4'hf, 4'hf, 4'h2, 0, 1'h0);
    endtask

    task automatic t_chain();
        for (int c = 0; c < 5; c++)
            for (int m = 0; m < 16; m++)
                frame_case(c, 4'(m), 4'hf, 4'h3, c,
                           exp_w(c, 4'(m)));
    endtask

    task automatic t_link();
        wr(`WFD_OFS_PMCS, 32'h100);
        link_up <= 1'h1;
        rdchk(`WFD_OFS_STATUS, 32'h6);
        wr(`WFD_OFS_STATUS, 32'h7);
        link_up <= 1'h0;
        fully_on <= 1'h1;
        @(posedge clk_sys);
        link_up <= 1'h1;
        rdchk(`WFD_OFS_STATUS, 32'h0);
        fully_on <= 1'h0;
    endtask

    task automatic t_rpo();
        pulse_rst();
        chk1(remote_wake_out, 1'h0);
        wait_id();
        wr(`WFD_OFS_PMCS, 32'h100);
        main_power_ok <= 1'h0;
        repeat (2) @(posedge clk_sys);
        #1 chk1(remote_power_on_mode, 1'h1);
        remote_wake_frame <= 1'h1;
        @(posedge clk_sys);
        remote_wake_frame <= 1'h0;
        @(posedge clk_sys);
        #1 chk1(remote_wake_out, 1'h1);
        main_power_ok <= 1'h1;
        pulse_rst();
        chk1(remote_wake_out, 1'h0);
        chk1(remote_power_on_mode, 1'h0);
        wait_id();
        main_power_ok <= 1'h0;
        repeat (2) @(posedge clk_sys);
        #1 chk1(remote_power_on_mode, 1'h1);
    endtask

    // =============================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'h0;
        t_reg();
        t_irq();
        t_gate();
        t_chain();
        t_link();
        t_rpo();
        stop_test();
    end
endmodule
